// ==== i2c_gc_pkg.sv ====
// Shared constants, register map and command codes for the two-wire slave and its master.
package i2c_gc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_PERIOD_NS = 64;
  localparam int HALF_LINK_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_END = 4'h9;
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;

  // Slave register map.
  localparam logic [7:0] OFS_BUFFER = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h0C;
  localparam logic [7:0] OFS_SLAVE_ADDR = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  localparam int BIT_BUFFER_FULL = 0;
  localparam int BIT_UPDATE_ADDR = 1;
  localparam int BIT_DIRECTION = 2;
  localparam int BIT_TEN_BIT = 0;
  localparam int BIT_CLOCK_RELEASE = 4;
  localparam int BIT_OVERFLOW = 6;
  localparam int BIT_STRETCH_EN = 0;
  localparam int BIT_GC_EN = 7;
  localparam int BIT_IRQ_EVENT = 0;

  localparam logic CLOCK_RELEASE_RST = 1'b1;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;

  // Master register map.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_TX_DATA = 8'h04;
  localparam logic [7:0] OFS_RX_DATA = 8'h08;
  localparam logic [7:0] OFS_MASTER_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASTER_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASTER_IRQ_MASK = 8'h14;

  localparam int BIT_CMD_NACK = 2;
  localparam int BIT_MST_BUSY = 0;
  localparam int BIT_MST_NACK = 1;

  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ = 2'b10,
    CMD_STOP = 2'b11
  } cmd_e;
endpackage : i2c_gc_pkg

// ==== i2c_link_if.sv ====
// Two-wire link between the bus master and the slave, with wired-AND line resolution.
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic mSclOut;
  logic mSclOen;
  logic mSdaOut;
  logic mSdaOen;
  logic sSclOut;
  logic sSclOen;
  logic sSdaOut;
  logic sSdaOen;
  logic scl;
  logic sda;

  // A released driver (enable high) lets the pull-up win.
  assign scl = (mSclOen | mSclOut) & (sSclOen | sSclOut);
  assign sda = (mSdaOen | mSdaOut) & (sSdaOen | sSdaOut);

  modport master (output mSclOut, output mSclOen, output mSdaOut, output mSdaOen,
                  input scl, input sda);
  modport slave (output sSclOut, output sSclOen, output sSdaOut, output sSdaOen,
                 input scl, input sda);
endinterface : i2c_link_if
`default_nettype wire

// ==== i2c_master_end.sv ====
// Bus master end: runs start, byte write, byte read and stop commands given over APB.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_end
  import i2c_gc_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_LINK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  i2c_link_if.master link,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_RS1 = 3'b001,
    M_RS2 = 3'b010,
    M_START = 3'b011,
    M_LOW = 3'b100,
    M_HIGH = 3'b101,
    M_STOP1 = 3'b110,
    M_STOP2 = 3'b111
  } mstate_e;

  localparam logic [15:0] HALF_LAST = 16'(HALF_CYCLES - 1);

  mstate_e state;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [15:0] tmr;
  logic [8:0] bits;
  logic [8:0] rxShift;
  logic [3:0] idx;
  logic sclLow;
  logic sdaLow;
  logic busy;
  logic busyPrev;
  logic doneFlag;
  logic doneMask;
  logic [7:0] txData;
  logic [31:0] rdValue;

  wire sclIn = sclSync[1];
  wire tmrDone = tmr == HALF_LAST;
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire mapped = paddr inside {OFS_CMD, OFS_TX_DATA, OFS_RX_DATA, OFS_MASTER_STATUS,
                              OFS_MASTER_IRQ_STATUS, OFS_MASTER_IRQ_MASK};
  wire cmdWr = wrEn && paddr == OFS_CMD && !busy;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign irq = doneFlag && doneMask;
  assign link.mSclOut = 1'b0;
  assign link.mSdaOut = 1'b0;
  assign link.mSclOen = !sclLow;
  assign link.mSdaOen = !sdaLow;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
    end
    else
    begin
      sclSync <= {sclSync[0], link.scl};
      sdaSync <= {sdaSync[0], link.sda};
    end
  end

  // The high phase timer restarts while the slave stretches the clock.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= M_IDLE;
      tmr <= 16'h0000;
      bits <= 9'h1FF;
      rxShift <= 9'h000;
      idx <= 4'h0;
      sclLow <= 1'b0;
      sdaLow <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      tmr <= tmr + 16'h0001;
      case (state)
        M_IDLE:
        begin
          tmr <= 16'h0000;
          if (cmdWr)
          begin
            busy <= 1'b1;
            idx <= 4'h0;
            case (cmd_e'(pwdata[1:0]))
              CMD_START: state <= M_RS1;
              CMD_WRITE:
              begin
                bits <= {txData, 1'b1};
                state <= M_LOW;
              end
              CMD_READ:
              begin
                bits <= {8'hFF, pwdata[BIT_CMD_NACK]};
                state <= M_LOW;
              end
              default:
              begin
                sdaLow <= 1'b1;
                state <= M_STOP1;
              end
            endcase
          end
        end
        M_RS1:
        begin
          sdaLow <= 1'b0;
          if (tmrDone)
          begin
            sclLow <= 1'b0;
            tmr <= 16'h0000;
            state <= M_RS2;
          end
        end
        M_RS2:
        begin
          if (!sclIn)
            tmr <= 16'h0000;
          else if (tmrDone)
          begin
            sdaLow <= 1'b1;
            tmr <= 16'h0000;
            state <= M_START;
          end
        end
        M_START:
        begin
          if (tmrDone)
          begin
            sclLow <= 1'b1;
            busy <= 1'b0;
            state <= M_IDLE;
          end
        end
        M_LOW:
        begin
          sdaLow <= !bits[8];
          if (tmrDone)
          begin
            sclLow <= 1'b0;
            tmr <= 16'h0000;
            state <= M_HIGH;
          end
        end
        M_HIGH:
        begin
          if (!sclIn)
            tmr <= 16'h0000;
          else if (tmrDone)
          begin
            rxShift <= {rxShift[7:0], sdaSync[1]};
            bits <= {bits[7:0], 1'b1};
            sclLow <= 1'b1;
            tmr <= 16'h0000;
            if (idx == CNT_ACK)
            begin
              sdaLow <= 1'b0;
              busy <= 1'b0;
              state <= M_IDLE;
            end
            else
            begin
              idx <= idx + 4'h1;
              state <= M_LOW;
            end
          end
        end
        M_STOP1:
        begin
          if (tmrDone)
          begin
            sclLow <= 1'b0;
            tmr <= 16'h0000;
            state <= M_STOP2;
          end
        end
        M_STOP2:
        begin
          if (!sclIn)
            tmr <= 16'h0000;
          else if (tmrDone)
          begin
            sdaLow <= 1'b0;
            busy <= 1'b0;
            state <= M_IDLE;
          end
        end
        default: state <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busyPrev <= 1'b0;
      doneFlag <= 1'b0;
      doneMask <= 1'b0;
      txData <= 8'h00;
    end
    else
    begin
      busyPrev <= busy;
      if (wrEn && paddr == OFS_TX_DATA)
        txData <= pwdata[7:0];
      if (wrEn && paddr == OFS_MASTER_IRQ_MASK)
        doneMask <= pwdata[BIT_IRQ_EVENT];
      if (wrEn && paddr == OFS_MASTER_IRQ_STATUS && pwdata[BIT_IRQ_EVENT])
        doneFlag <= 1'b0;
      if (busyPrev && !busy)
        doneFlag <= 1'b1;
    end
  end

  always_comb
  begin
    rdValue = 32'h0000_0000;
    case (paddr)
      OFS_TX_DATA: rdValue[7:0] = txData;
      OFS_RX_DATA: rdValue[7:0] = rxShift[8:1];
      OFS_MASTER_STATUS:
      begin
        rdValue[BIT_MST_BUSY] = busy;
        rdValue[BIT_MST_NACK] = rxShift[0];
      end
      OFS_MASTER_IRQ_STATUS: rdValue[BIT_IRQ_EVENT] = doneFlag;
      OFS_MASTER_IRQ_MASK: rdValue[BIT_IRQ_EVENT] = doneMask;
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rdValue;
  end
endmodule : i2c_master_end
`default_nettype wire

// ==== i2c_slave_end.sv ====
// Two-wire slave: address match, receive, transmit, general call, 10-bit addressing, APB regs.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Write-address match: clear direction, buffer address, acknowledge.
// RULE2: No address acknowledge while buffer full or overflow.
// RULE3: Flag every transferred byte; software clears it. Code flags only sent bytes and received bytes it acknowledges.
// RULE4: Stretch enabled: hold clock after received byte.
// RULE5: Read-address match: set direction, acknowledge, hold clock.
// RULE6: Buffer write loads shifter; release bit frees clock.
// RULE7: Transmit eight bits, changing on falling clock.
// RULE8: Master no-acknowledge on ninth rise ends transfer.
// RULE9: After acknowledge, software loads next byte, releases.
// RULE10: Transmit flag set on ninth falling edge.
// RULE11: All-zero write address is general call.
// RULE12: General call honoured only when enabled. Code still acks 0x00 as own address if slaveAddr[7:1] is zero.
// RULE13: Shift eight bits after start, compare both addresses.
// RULE14: General call: buffer and full at eighth bit.
// RULE15: Software reads buffer to tell call type.
// RULE16: 10-bit mode sets update-address; software rewrites address.
// RULE17: 10-bit general call skips second half.
// RULE18: Release data line unless acknowledging or sending zero.
module i2c_slave_end
  import i2c_gc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  i2c_link_if.slave link,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR2 = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100
  } sstate_e;

  sstate_e state;
  sstate_e afterState;
  sstate_e nextAfter;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic sclPrev;
  logic sdaPrev;
  logic [3:0] cnt;
  logic [7:0] shiftReg;
  logic [7:0] txShift;
  logic ackOn;
  logic txOn;
  logic willAck;
  logic masterNack;
  logic hold;
  logic [7:0] buffer;
  logic bufferFull;
  logic updateAddr;
  logic direction;
  logic overflow;
  logic clockRelease;
  logic tenBit;
  logic stretchEn;
  logic general_call_enable;
  logic [7:0] slaveAddr;
  logic eventFlag;
  logic eventMask;
  logic matchAck;
  logic setUa;
  logic gcHit;
  logic [31:0] rdValue;

  wire sclRise = sclSync[1] && !sclPrev;
  wire sclFall = !sclSync[1] && sclPrev;
  wire startSeen = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
  wire stopSeen = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];
  wire [7:0] byteIn = {shiftReg[6:0], sdaSync[1]};
  wire rxState = state == ST_ADDR || state == ST_ADDR2 || state == ST_RX;
  wire byteDone = sclRise && cnt == CNT_LAST_DATA && rxState && !startSeen && !stopSeen;
  wire take = byteDone && matchAck && !(bufferFull || overflow);
  wire endFall = sclFall && cnt == CNT_END && state != ST_IDLE && !startSeen && !stopSeen;
  wire holdStart = endFall && (state == ST_TX ? !masterNack :
                   (afterState == ST_TX || (afterState != ST_IDLE && stretchEn)));

  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  wire mapped = paddr inside {OFS_BUFFER, OFS_STATUS, OFS_CTRL_ONE, OFS_CTRL_TWO,
                              OFS_SLAVE_ADDR, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  wire bufWrite = wrEn && paddr == OFS_BUFFER;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign irq = eventFlag && eventMask;
  assign link.sSdaOut = 1'b0;
  assign link.sSclOut = 1'b0;
  assign link.sSdaOen = !(ackOn || (txOn && state == ST_TX && !txShift[7])); // [RULE18] [RULE7]
  assign link.sSclOen = !hold; // [RULE4] [RULE5]

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclSync <= {sclSync[0], link.scl};
      sdaSync <= {sdaSync[0], link.sda};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  // Address and data byte decision taken at the eighth rising clock edge.
  always_comb
  begin
    matchAck = 1'b0;
    setUa = 1'b0;
    nextAfter = ST_IDLE;
    gcHit = general_call_enable && byteIn == GENERAL_CALL_ADDR; // [RULE11] [RULE12]
    case (state)
      ST_ADDR:
      begin
        if (gcHit)
        begin
          matchAck = 1'b1;
          nextAfter = ST_RX; // [RULE17]
        end
        else if (byteIn[7:1] == slaveAddr[7:1]) // [RULE13]
        begin
          matchAck = 1'b1;
          setUa = tenBit && !byteIn[0]; // [RULE16]
          nextAfter = byteIn[0] ? ST_TX : (tenBit ? ST_ADDR2 : ST_RX);
        end
      end
      ST_ADDR2:
      begin
        if (byteIn == slaveAddr)
        begin
          matchAck = 1'b1;
          setUa = 1'b1; // [RULE16]
          nextAfter = ST_RX;
        end
      end
      ST_RX:
      begin
        matchAck = 1'b1;
        nextAfter = ST_RX;
      end
      default: nextAfter = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      afterState <= ST_IDLE;
      cnt <= 4'h0;
      shiftReg <= 8'h00;
      txShift <= 8'h00;
      ackOn <= 1'b0;
      txOn <= 1'b0;
      willAck <= 1'b0;
      masterNack <= 1'b0;
      hold <= 1'b0;
    end
    else if (startSeen || stopSeen)
    begin
      state <= startSeen ? ST_ADDR : ST_IDLE; // [RULE13]
      cnt <= 4'h0;
      ackOn <= 1'b0;
      txOn <= 1'b0;
      hold <= 1'b0;
    end
    else
    begin
      // Loading the buffer arms the transmit driver, so no stale bit reaches the line.
      if (bufWrite)
      begin
        txShift <= pwdata[7:0]; // [RULE6]
        txOn <= 1'b1; // [RULE6] [RULE18]
      end
      if (holdStart)
        hold <= 1'b1; // [RULE4] [RULE5]
      else if (hold && clockRelease)
        hold <= 1'b0; // [RULE6] [RULE9]
      if (state != ST_IDLE && sclRise)
      begin
        if (cnt < CNT_ACK)
          shiftReg <= byteIn;
        cnt <= cnt + 4'h1;
        if (byteDone)
        begin
          willAck <= take; // [RULE2]
          afterState <= take ? nextAfter : ST_IDLE;
        end
        if (state == ST_TX && cnt == CNT_ACK)
          masterNack <= sdaSync[1]; // [RULE8]
      end
      if (state != ST_IDLE && sclFall)
      begin
        if (cnt == CNT_ACK)
        begin
          ackOn <= willAck && state != ST_TX; // [RULE1] [RULE5]
          txOn <= 1'b0;
        end
        else if (cnt == CNT_END)
        begin
          ackOn <= 1'b0;
          cnt <= 4'h0;
          txOn <= bufWrite; // [RULE18]
          if (state == ST_TX)
            state <= masterNack ? ST_IDLE : ST_TX; // [RULE8]
          else
            state <= afterState;
        end
        else if (state == ST_TX && txOn && cnt != 4'h0 && !bufWrite)
          txShift <= {txShift[6:0], 1'b0}; // [RULE7]
      end
    end
  end

  // Byte capture and status bits; a hardware set wins over a same-cycle software clear.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buffer <= 8'h00;
      bufferFull <= 1'b0;
      overflow <= 1'b0;
      updateAddr <= 1'b0;
      direction <= 1'b0;
    end
    else
    begin
      if (bufWrite)
        buffer <= pwdata[7:0]; // [RULE6]
      if (rdEn && paddr == OFS_BUFFER)
        bufferFull <= 1'b0;
      if (wrEn && paddr == OFS_CTRL_ONE && !pwdata[BIT_OVERFLOW])
        overflow <= 1'b0;
      if (wrEn && paddr == OFS_SLAVE_ADDR)
        updateAddr <= 1'b0;
      if (take)
      begin
        buffer <= byteIn; // [RULE1] [RULE5] [RULE14] [RULE15]
        bufferFull <= 1'b1; // [RULE14]
        if (setUa)
          updateAddr <= 1'b1; // [RULE16] [RULE17]
        if (state == ST_ADDR)
          direction <= byteIn[0] && !gcHit; // [RULE1] [RULE5]
      end
      if (byteDone && matchAck && (bufferFull || overflow))
        overflow <= 1'b1; // [RULE2]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clockRelease <= CLOCK_RELEASE_RST;
      tenBit <= 1'b0;
      stretchEn <= 1'b0;
      general_call_enable <= 1'b0;
      slaveAddr <= SLAVE_ADDR_RST;
      eventMask <= 1'b0;
      eventFlag <= 1'b0;
    end
    else
    begin
      if (wrEn && paddr == OFS_CTRL_ONE)
      begin
        clockRelease <= pwdata[BIT_CLOCK_RELEASE]; // [RULE6]
        tenBit <= pwdata[BIT_TEN_BIT];
      end
      else if (holdStart)
        clockRelease <= 1'b0; // [RULE5]
      if (wrEn && paddr == OFS_CTRL_TWO)
      begin
        stretchEn <= pwdata[BIT_STRETCH_EN];
        general_call_enable <= pwdata[BIT_GC_EN];
      end
      if (wrEn && paddr == OFS_SLAVE_ADDR)
        slaveAddr <= pwdata[7:0];
      if (wrEn && paddr == OFS_IRQ_MASK)
        eventMask <= pwdata[BIT_IRQ_EVENT];
      if (wrEn && paddr == OFS_IRQ_STATUS && pwdata[BIT_IRQ_EVENT])
        eventFlag <= 1'b0; // [RULE3]
      if (endFall && (ackOn || state == ST_TX))
        eventFlag <= 1'b1; // [RULE3] [RULE10] [RULE14]
    end
  end

  always_comb
  begin
    rdValue = 32'h0000_0000;
    case (paddr)
      OFS_BUFFER: rdValue[7:0] = buffer;
      OFS_STATUS:
      begin
        rdValue[BIT_BUFFER_FULL] = bufferFull;
        rdValue[BIT_UPDATE_ADDR] = updateAddr;
        rdValue[BIT_DIRECTION] = direction;
      end
      OFS_CTRL_ONE:
      begin
        rdValue[BIT_OVERFLOW] = overflow;
        rdValue[BIT_CLOCK_RELEASE] = clockRelease;
        rdValue[BIT_TEN_BIT] = tenBit;
      end
      OFS_CTRL_TWO:
      begin
        rdValue[BIT_STRETCH_EN] = stretchEn;
        rdValue[BIT_GC_EN] = general_call_enable;
      end
      OFS_SLAVE_ADDR: rdValue[7:0] = slaveAddr;
      OFS_IRQ_STATUS: rdValue[BIT_IRQ_EVENT] = eventFlag;
      OFS_IRQ_MASK: rdValue[BIT_IRQ_EVENT] = eventMask;
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rdValue;
  end
endmodule : i2c_slave_end
`default_nettype wire

// ==== i2c_slave_rx_tx_general_call_chk.sv ====
// Link checker for the two-wire slave and master ends.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_rx_tx_general_call_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic mSclOen,
  input wire logic sSclOut,
  input wire logic sSclOen,
  input wire logic sSdaOut,
  input wire logic sSdaOen,
  input wire logic scl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_out_zero;
    !sSdaOut && !sSclOut;
  endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("slave output level is not low");
  property p_drive_low;
    $fell(sSdaOen) |-> !scl;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("slave pulled data low while clock high");
  property p_ack_held;
    $fell(sSdaOen) |=> !sSdaOen [*8];
  endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("slave low data bit too short");
  property p_sda_stable;
    scl && $past(scl) |-> $stable(sSdaOen);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("slave data changed while clock high");
  property p_stretch_on_low;
    $fell(sSclOen) |-> !$past(scl);
  endproperty
  a_stretch_on_low: assert property (p_stretch_on_low)
    else $error("slave grabbed clock while it was high");
  property p_stretch_held;
    $fell(sSclOen) |=> !sSclOen [*2];
  endproperty
  a_stretch_held: assert property (p_stretch_held)
    else $error("slave clock hold ended at once");
  property p_stretch_sda_free;
    $fell(sSclOen) |-> sSdaOen;
  endproperty
  a_stretch_sda_free: assert property (p_stretch_sda_free)
    else $error("slave holds data while stretching");
  property p_master_low;
    $fell(mSclOen) |=> !mSclOen [*6];
  endproperty
  a_master_low: assert property (p_master_low)
    else $error("master clock low phase too short");
endmodule : i2c_slave_rx_tx_general_call_chk
`default_nettype wire

// ==== i2c_slave_rx_tx_general_call_tb.sv ====
// Bench joining the master and slave ends over the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_rx_tx_general_call_tb;
  import i2c_gc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr [2];
  logic psel [2];
  logic penable [2];
  logic pwrite [2];
  logic [31:0] pwdata [2];
  logic [31:0] prdata [2];
  logic pready [2];
  logic pslverr [2];
  logic irq [2];
  logic [31:0] rd;
  logic err;
  logic [6:0] addr;
  logic [7:0] dat;
  logic [7:0] rxq [$];
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int mBf = 0;
  int mOv = 0;
  int mGc = 0;

  i2c_link_if link ();
  i2c_master_end u_i2c_master_end (.clk(clk), .rst(rst), .link(link), .paddr(paddr[0]),
    .psel(psel[0]), .penable(penable[0]), .pwrite(pwrite[0]), .pwdata(pwdata[0]),
    .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]), .irq(irq[0]));
  i2c_slave_end u_i2c_slave_end (.clk(clk), .rst(rst), .link(link), .paddr(paddr[1]),
    .psel(psel[1]), .penable(penable[1]), .pwrite(pwrite[1]), .pwdata(pwdata[1]),
    .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]), .irq(irq[1]));
  i2c_slave_rx_tx_general_call_chk u_i2c_slave_rx_tx_general_call_chk (.clk(clk),
    .rst(rst), .mSclOen(link.mSclOen), .sSclOut(link.sSclOut), .sSclOen(link.sSclOen),
    .sSdaOut(link.sSdaOut), .sSdaOen(link.sSdaOen), .scl(link.scl));

  initial
    forever #2 clk = ~clk;

  task automatic give_verdict();
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input int e, input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel[e] <= 1'b1;
    paddr[e] <= a;
    pwrite[e] <= w;
    pwdata[e] <= d;
    @(posedge clk);
    penable[e] <= 1'b1;
    do @(posedge clk); while (pready[e] !== 1'b1);
    rd = prdata[e];
    err = pslverr[e];
    psel[e] <= 1'b0;
    penable[e] <= 1'b0;
    #1;
  endtask : apb

  task automatic sr(input logic [7:0] a);
    apb(1, a, 1'b0, 32'h0);
  endtask : sr

  task automatic sw(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, 1'b1, d);
  endtask : sw

  // Slave sync delay is a few clocks, so the pause lets its flags settle.
  task automatic cmd(input logic [2:0] c);
    apb(0, OFS_CMD, 1'b1, {29'h0, c});
    do apb(0, OFS_MASTER_STATUS, 1'b0, 32'h0); while (rd[BIT_MST_BUSY] !== 1'b0);
    repeat (8) @(posedge clk);
  endtask : cmd

  task automatic send(input logic [7:0] b, input logic n);
    apb(0, OFS_TX_DATA, 1'b1, {24'h0, b});
    cmd(3'(CMD_WRITE));
    apb(0, OFS_MASTER_STATUS, 1'b0, 32'h0);
    chk(8'(rd[BIT_MST_NACK]), 8'(n));
  endtask : send

  task automatic rdbuf();
    sr(OFS_BUFFER);
    chk(rd[7:0], rxq.pop_front());
    mBf = 0;
  endtask : rdbuf

  task automatic put(input logic [7:0] b);
    send(b, mBf != 0);
    if (mBf != 0)
      mOv = 1;
    else
    begin
      mBf = 1;
      rxq.push_back(b);
    end
  endtask : put

  task automatic hit(input logic [7:0] b);
    logic n;
    n = (mBf != 0 || mOv != 0) ? 1'b1 : (b == 8'h00) ? (mGc == 0) : (b[7:1] != addr);
    cmd(3'(CMD_START));
    send(b, n);
    if (n)
      cmd(3'(CMD_STOP));
    else
    begin
      mBf = 1;
      rxq.push_back(b);
    end
  endtask : hit

  initial
  begin
    void'($urandom(32'h4F4D9811));
    foreach (psel[i])
    begin
      psel[i] = 1'b0;
      penable[i] = 1'b0;
      pwrite[i] = 1'b0;
      paddr[i] = 8'h00;
      pwdata[i] = 32'h0;
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    addr = 7'($urandom_range(119, 1));
    sr(OFS_CTRL_ONE);
    chk(8'(rd[BIT_CLOCK_RELEASE]), 8'h01);
    sr(8'h1C);
    chk(8'({err, rd[7:0] != 8'h00}), 8'h02);
    sw(OFS_SLAVE_ADDR, {24'h0, addr, 1'b0});
    sw(OFS_IRQ_MASK, 32'h1);
    sw(OFS_CTRL_TWO, 32'h1);
    hit({addr, 1'b0});
    sr(OFS_STATUS);
    chk(8'(rd[2:0]), 8'h01);
    chk(8'(irq[1]), 8'h01);
    rdbuf();
    sw(OFS_CTRL_ONE, 32'h10);
    sw(OFS_IRQ_STATUS, 32'h1);
    chk(8'(irq[1]), 8'h00);
    repeat (2)
    begin
      dat = 8'($urandom);
      put(dat);
      sr(OFS_CTRL_ONE);
      chk(8'({link.sSclOen, rd[BIT_CLOCK_RELEASE]}), 8'h00);
      rdbuf();
      sw(OFS_CTRL_ONE, 32'h10);
    end
    chk(8'(irq[1]), 8'h01);
    sw(OFS_CTRL_TWO, 32'h0);
    put(8'h5A);
    put(8'hA5);
    cmd(3'(CMD_STOP));
    sr(OFS_CTRL_ONE);
    chk(8'(rd[BIT_OVERFLOW]), 8'h01);
    hit({addr, 1'b0});
    rdbuf();
    hit({addr, 1'b0});
    sw(OFS_CTRL_ONE, 32'h10);
    mOv = 0;
    hit({~addr, 1'b0});
    hit({addr, 1'b1});
    sr(OFS_STATUS);
    chk(8'(rd[2:0]), 8'h05);
    sr(OFS_CTRL_ONE);
    chk(8'({link.sSclOen, rd[BIT_CLOCK_RELEASE]}), 8'h00);
    rdbuf();
    for (int k = 0; k < 2; k++)
    begin
      sw(OFS_IRQ_STATUS, 32'h1);
      dat = 8'($urandom);
      sw(OFS_BUFFER, {24'h0, dat});
      sw(OFS_CTRL_ONE, 32'h10);
      cmd({k[0], CMD_READ});
      apb(0, OFS_RX_DATA, 1'b0, 32'h0);
      chk(rd[7:0], dat);
      chk(8'({irq[1], link.sSclOen, link.sSdaOen}), k ? 8'h07 : 8'h05);
    end
    cmd(3'(CMD_STOP));
    sr(OFS_BUFFER);
    for (int g = 0; g < 2; g++)
    begin
      mGc = g;
      sw(OFS_CTRL_TWO, 32'(g) << BIT_GC_EN);
      hit(8'h00);
    end
    sr(OFS_STATUS);
    chk(8'(rd[BIT_BUFFER_FULL]), 8'h01);
    rdbuf();
    put(8'h96);
    rdbuf();
    sw(OFS_CTRL_ONE, 32'h11);
    sw(OFS_SLAVE_ADDR, 32'hF2);
    cmd(3'(CMD_START));
    send(8'hF2, 1'b0);
    sr(OFS_STATUS);
    chk(8'(rd[BIT_UPDATE_ADDR]), 8'h01);
    sr(OFS_BUFFER);
    sw(OFS_SLAVE_ADDR, {24'h0, dat});
    send(dat, 1'b0);
    sr(OFS_BUFFER);
    put(8'h3C);
    rdbuf();
    sw(OFS_SLAVE_ADDR, 32'hF2);
    cmd(3'(CMD_START));
    send(8'h00, 1'b0);
    sr(OFS_STATUS);
    chk(8'(rd[1:0]), 8'h01);
    sr(OFS_BUFFER);
    put(8'hC3);
    rdbuf();
    cmd(3'(CMD_STOP));
    give_verdict();
  end
endmodule : i2c_slave_rx_tx_general_call_tb
`default_nettype wire
